// File: hdl/usm_pkg.sv
`default_nettype none
package usm_pkg;
  // Frame and divisor widths.
  localparam int unsigned USM_DATA_W = 8;
  localparam int unsigned USM_DIV_W = 12;
  localparam int unsigned USM_EDGES = 2 * USM_DATA_W;
  // Receive buffer holds this many unread bytes.
  localparam int unsigned USM_RXQ_DEPTH = 2;
  // Mode select code that enables master transfers.
  localparam logic [1:0] USM_MODE_MASTER = 2'h3;
  // Reset values.
  localparam logic [11:0] USM_DIV_RST = 12'h000;
  localparam logic USM_TBE_RST = 1'b1;
  localparam logic USM_LINE_IDLE = 1'b1;
  // Shift engine states.
  typedef enum logic [0:0] {
    USM_IDLE = 1'b0,
    USM_SHIFT = 1'b1
  } usm_state_t;
endpackage : usm_pkg
`default_nettype wire

// File: hdl/usm_rxq_if.sv
`default_nettype none
interface usm_rxq_if;
  logic push;
  logic [7:0] push_data;
  logic pop;
  logic flush;
  logic [7:0] head;
  logic not_empty;
  logic [1:0] count;
  modport engine (output push, output push_data, output pop, output flush,
                  input head, input not_empty, input count);
  modport buffer (input push, input push_data, input pop, input flush,
                  output head, output not_empty, output count);
endinterface : usm_rxq_if
`default_nettype wire

// File: hdl/usm_rxq.sv
`default_nettype none
module usm_rxq (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic nrst,
  // Engine side.
  usm_rxq_if.buffer q
);
  import usm_pkg::*;

  // [RULE_24] two-deep receive buffer
  logic [7:0] slot_q [USM_RXQ_DEPTH];
  logic [1:0] cnt_q;
  logic ne_q;

  // Shift-style queue: slot 0 is the head, so read data always come from a register.
  // [RULE_16] newest byte dropped
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 2'h0;
      slot_q[0] <= 8'h00;
      slot_q[1] <= 8'h00;
    end else if (q.flush) begin
      cnt_q <= 2'h0;
    end else if (q.pop && cnt_q != 2'h0) begin
      slot_q[0] <= (cnt_q == 2'h2) ? slot_q[1] : q.push_data;
      if (cnt_q == 2'h2) begin
        slot_q[1] <= q.push_data;
      end
      cnt_q <= q.push ? cnt_q : cnt_q - 2'h1;
    end else if (q.push && cnt_q != 2'h2) begin
      if (cnt_q == 2'h0) begin
        slot_q[0] <= q.push_data;
      end else begin
        slot_q[1] <= q.push_data;
      end
      cnt_q <= cnt_q + 2'h1;
    end
  end

  assign q.head = slot_q[0];
  assign q.count = cnt_q;
  // Not-empty kept in its own flop so the status pin comes straight from a register.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ne_q <= 1'b0;
    end else if (q.flush) begin
      ne_q <= 1'b0;
    end else if (q.pop && cnt_q == 2'h1) begin
      ne_q <= q.push;
    end else if (q.push) begin
      ne_q <= 1'b1;
    end
  end
  assign q.not_empty = ne_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_ovf_keeps_old: assert property ( // RULE_16
    (cnt_q == 2'h2 && q.push && !q.pop && !q.flush) |=> $stable(slot_q[0]) && $stable(slot_q[1])
  ) else $error("Overflow altered buffered bytes.");
  a_depth_two: assert property ( // RULE_24
    (cnt_q == 2'h1 && q.push && !q.pop && !q.flush) |=> cnt_q == 2'h2 && slot_q[1] == $past(q.push_data)
  ) else $error("Second byte not held.");
  c_overflow: cover property (cnt_q == 2'h2 && q.push && !q.pop);
endmodule : usm_rxq
`default_nettype wire

// File: hdl/usm_master.sv
// Contract
// [RULE_01] Polarity and phase select four SPI modes
// [RULE_02] Drive and capture on opposite clock edges
// [RULE_03] Software keeps mode bits still mid-transfer
// [RULE_04] Frames are exactly eight data bits
// [RULE_05] One bit-order setting for both directions
// [RULE_06] Chain next frame or idle line high
// [RULE_07] Two writes send sixteen bits, done after
// [RULE_08] Transmitter runs alone; receiver never clocks
// [RULE_09] Software loads divisor after enabling transmitter
// [RULE_10] Divisor register resets to zero
// [RULE_11] Software clears done flag before writing
// [RULE_12] Transmitter owns serial output pin
// [RULE_13] Receiver owns serial input pin
// [RULE_14] Only data writes start a transfer
// [RULE_15] Buffered byte loads once shifter free
// [RULE_16] Overflow drops newest, keeps older bytes
// [RULE_17] Framing, overrun, parity flags read zero
// [RULE_18] Clock pin always carries transfer clock
// [RULE_19] Software checks idle before reinitialising
// [RULE_20] Master mode only when both bits set
// [RULE_21] Clock is system over twice divisor+1
// [RULE_22] Buffer-empty flag set after reset
// [RULE_23] Disable waits until shifter and buffer empty
// [RULE_24] Receive buffer holds more than one byte
`default_nettype none
module usm_master (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic nrst,
  // Configuration.
  input wire logic [1:0] mode_select_field,
  input wire logic clock_polarity_sel,
  input wire logic clock_phase_sel,
  input wire logic bit_order_sel,
  input wire logic tx_enable_bit,
  input wire logic rx_enable_bit,
  // Divisor write port.
  input wire logic rate_divisor_wr,
  input wire logic [usm_pkg::USM_DIV_W-1:0] rate_divisor_wdata,
  output logic [usm_pkg::USM_DIV_W-1:0] rate_divisor,
  // Data window.
  input wire logic data_window_wr,
  input wire logic [usm_pkg::USM_DATA_W-1:0] data_window_wdata,
  input wire logic data_window_rd,
  output logic [usm_pkg::USM_DATA_W-1:0] data_window_rdata,
  // Status.
  input wire logic tx_done_clr,
  output logic tx_done_flag,
  output logic tx_buf_empty_flag,
  output logic rx_full_flag,
  output logic framing_err_flag,
  output logic overrun_flag,
  output logic parity_err_flag,
  // Pins.
  output logic xfer_clock_pin,
  output logic serial_out_pin,
  output logic serial_out_oe_n,
  input wire logic serial_in_pin,
  output logic serial_in_owned
);
  import usm_pkg::*;

  usm_state_t state_q;
  logic [USM_DIV_W-1:0] div_q, cnt_q;
  logic [3:0] edge_q;
  logic [7:0] tbuf_q, tsr_q, rsr_q;
  logic tbuf_v_q, sck_q, sout_q, done_q, txact_q, rxown_q, zero_q;
  logic sin_m_q, sin_s_q;
  logic tick, last, start, sample, setup;
  logic txact_d, oen_q, tbe_q;
  logic [7:0] rx_word;
  logic [2:0] rx_idx, tx_idx;
  usm_rxq_if rq ();

  // Picks the bit for a given position under the chosen bit order.
  // [RULE_05] shared order select
  function automatic logic [2:0] pos(input logic [2:0] n, input logic lsb);
    pos = lsb ? n : 3'h7 - n;
  endfunction : pos

  // Edge decode: a clock edge falls due when the half-period count expires.
  assign tick = (state_q == USM_SHIFT) && (cnt_q == '0);
  assign last = tick && (edge_q == 4'(USM_EDGES - 1));
  // [RULE_01] sample on leading when phase clear
  assign sample = tick && (edge_q[0] == clock_phase_sel);
  // [RULE_02] setup on the opposite edge
  assign setup = tick && (edge_q[0] != clock_phase_sel) && !last;
  assign rx_idx = pos(edge_q[3:1], bit_order_sel);
  assign tx_idx = pos(clock_phase_sel ? edge_q[3:1] : edge_q[3:1] + 3'h1, bit_order_sel);
  // [RULE_20] master mode gate
  // [RULE_23] keep going while work remains
  // [RULE_08] transmitter alone produces clock
  assign start = tbuf_v_q && (mode_select_field == USM_MODE_MASTER) &&
                 (tx_enable_bit || txact_q) && (state_q == USM_IDLE || last);

  // Input pin synchroniser.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sin_m_q <= 1'b0;
      sin_s_q <= 1'b0;
    end else begin
      sin_m_q <= serial_in_pin;
      sin_s_q <= sin_m_q;
    end
  end

  // Divisor register.
  // [RULE_10] reset to zero
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      div_q <= USM_DIV_RST;
    end else if (rate_divisor_wr) begin
      div_q <= rate_divisor_wdata;
    end
  end

  // Transmit holding buffer.
  // [RULE_22] empty after reset
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tbuf_v_q <= !USM_TBE_RST;
      tbe_q <= USM_TBE_RST;
      tbuf_q <= 8'h00;
    end else if (data_window_wr && !tbuf_v_q) begin
      // [RULE_14] write starts transfer
      tbuf_v_q <= 1'b1;
      tbe_q <= 1'b0;
      tbuf_q <= data_window_wdata;
    end else if (start) begin
      tbuf_v_q <= 1'b0;
      tbe_q <= 1'b1;
    end
  end

  // Shift engine: state, half-period counter, edge count and clock level.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= USM_IDLE;
      cnt_q <= '0;
      edge_q <= 4'h0;
      sck_q <= 1'b0;
    end else if (start) begin
      // [RULE_15] load as soon as free
      state_q <= USM_SHIFT;
      cnt_q <= div_q;
      edge_q <= 4'h0;
      sck_q <= clock_polarity_sel;
    end else begin
      unique case (state_q)
        USM_IDLE: begin
          sck_q <= clock_polarity_sel;
        end
        USM_SHIFT: begin
          if (tick) begin
            // [RULE_21] reload divisor each half period
            cnt_q <= div_q;
            edge_q <= edge_q + 4'h1;
            sck_q <= !sck_q;
            // [RULE_04] sixteen edges make eight bits
            if (last) begin
              state_q <= USM_IDLE;
            end
          end else begin
            cnt_q <= cnt_q - 12'h001;
          end
        end
      endcase
    end
  end

  // Outgoing data: first bit at load when phase clear, others on setup edges.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tsr_q <= 8'h00;
      sout_q <= USM_LINE_IDLE;
    end else if (start) begin
      tsr_q <= tbuf_q;
      sout_q <= clock_phase_sel ? sout_q : tbuf_q[pos(3'h0, bit_order_sel)];
    end else if (setup) begin
      sout_q <= tsr_q[tx_idx];
    end else if (state_q == USM_IDLE) begin
      // The last bit is held past the final edge, so the far side never samples a change.
      // [RULE_06] idle line high
      sout_q <= USM_LINE_IDLE;
    end
  end

  // Incoming data capture and push to the receive buffer.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rsr_q <= 8'h00;
    end else if (sample) begin
      rsr_q[rx_idx] <= sin_s_q;
    end
  end

  // Receive queue hookup; a disabled receiver flushes the buffer and pushes nothing, though the shift register still samples.
  // [RULE_13] receiver gated by enable
  assign rq.push = last && rx_enable_bit;
  // With phase set the final sample edge is the push cycle, so that bit is merged in here.
  assign rx_word = sample ? ((rsr_q & ~(8'h01 << rx_idx)) | ({7'h00, sin_s_q} << rx_idx))
                          : rsr_q;
  assign rq.push_data = rx_word;
  assign rq.pop = data_window_rd;
  assign rq.flush = !rx_enable_bit;
  usm_rxq u_rxq (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .q(rq.buffer)
  );

  // Transmit-complete flag; a new completion wins over a clear.
  // [RULE_07] done only when nothing queued
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      done_q <= 1'b0;
    end else if (last && !start) begin
      done_q <= 1'b1;
    end else if (tx_done_clr) begin
      done_q <= 1'b0;
    end
  end

  // Pin ownership; a disabled transmitter keeps the pin only while its own work remains.
  // [RULE_12] transmitter owns output
  assign txact_d = tx_enable_bit || (txact_q && (state_q == USM_SHIFT || tbuf_v_q));
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      txact_q <= 1'b0;
      oen_q <= 1'b1;
      rxown_q <= 1'b0;
    end else begin
      txact_q <= txact_d;
      oen_q <= !txact_d;
      rxown_q <= rx_enable_bit;
    end
  end

  // Receiver error flags have no meaning here.
  // [RULE_17] always zero
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      zero_q <= 1'b0;
    end else begin
      zero_q <= 1'b0;
    end
  end

  // Outputs straight from registers.
  // [RULE_18] clock pin driven always
  assign xfer_clock_pin = sck_q;
  assign serial_out_pin = sout_q;
  assign serial_out_oe_n = oen_q;
  assign serial_in_owned = rxown_q;
  assign rate_divisor = div_q;
  assign tx_done_flag = done_q;
  assign tx_buf_empty_flag = tbe_q;
  assign rx_full_flag = rq.not_empty;
  assign data_window_rdata = rq.head;
  assign framing_err_flag = zero_q;
  assign overrun_flag = zero_q;
  assign parity_err_flag = zero_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_clk_idle_pol: assert property ( // RULE_01
    (state_q == USM_IDLE && $past(state_q == USM_IDLE) && $stable(clock_polarity_sel))
      |-> xfer_clock_pin == clock_polarity_sel
  ) else $error("Idle clock level differs from polarity.");
  a_edge_toggles: assert property ( // RULE_02
    tick |=> xfer_clock_pin != $past(xfer_clock_pin)
  ) else $error("Clock did not toggle on edge.");
  a_div_reload: assert property ( // RULE_21
    (tick && !start) |=> cnt_q == $past(div_q)
  ) else $error("Half period not reloaded from divisor.");
  a_errs_zero: assert property ( // RULE_17
    !framing_err_flag && !overrun_flag && !parity_err_flag
  ) else $error("Error flag not zero.");
  a_load_prompt: assert property ( // RULE_15
    (state_q == USM_IDLE && tbuf_v_q && tx_enable_bit && mode_select_field == USM_MODE_MASTER)
      |=> state_q == USM_SHIFT && tx_buf_empty_flag
  ) else $error("Buffered byte not loaded.");
  a_write_only_start: assert property ( // RULE_14
    (state_q == USM_IDLE && !tbuf_v_q) |=> state_q == USM_IDLE
  ) else $error("Transfer began without a write.");
  a_mode_gate: assert property ( // RULE_20
    (state_q == USM_IDLE && mode_select_field != USM_MODE_MASTER) |=> state_q == USM_IDLE
  ) else $error("Transfer outside master mode.");
  a_done_late: assert property ( // RULE_07
    $rose(tx_done_flag) |-> $past(last) && $past(!tbuf_v_q)
  ) else $error("Done raised with data pending.");
  a_pin_held: assert property ( // RULE_23
    ((tx_enable_bit || txact_q) && (state_q == USM_SHIFT || tbuf_v_q)) |=> !serial_out_oe_n
  ) else $error("Output released while busy.");
  a_idle_high: assert property ( // RULE_06
    (state_q == USM_IDLE && $past(state_q == USM_IDLE)) |-> serial_out_pin
  ) else $error("Idle line not high.");
  c_frame_done: cover property (last);
  c_back_to_back: cover property (last && start);
  c_lsb_mode3: cover property (last && bit_order_sel && clock_phase_sel && clock_polarity_sel);
endmodule : usm_master
`default_nettype wire

// File: verif/usm_slave.sv
`default_nettype none
module usm_slave (
  // Serial lines.
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  // Frame setup from the bench.
  input wire logic pol,
  input wire logic pha,
  input wire logic lsb_first,
  input wire logic arm,
  input wire logic [7:0] reply,
  // Captured results.
  output logic [7:0] got,
  output var int frames
);
  timeunit 1ns;
  timeprecision 1ns;
  int e = 0;
  int idx;
  logic [7:0] sr;

  // Counters start from zero before any clock edge arrives.
  initial begin
    frames = 0;
    got = 8'h00;
  end

  // shared bit order
  // Present the reply bit for the current position in the frame.
  always_comb begin
    idx = pha ? (e > 0 ? (e - 1) / 2 : 0) : e / 2;
    miso = reply[lsb_first ? idx : 7 - idx];
  end

  // edge roles, eight bits
  // Capture on sample edges and close the frame after the sixteenth edge.
  always @(posedge sck or negedge sck or negedge arm) begin
    if (!arm) begin
      e = 0;
    end else begin
      if (sck != (pol ^ pha)) begin
        sr = lsb_first ? {mosi, sr[7:1]} : {sr[6:0], mosi};
      end
      e = e + 1;
      if (e == 16) begin
        got <= sr;
        frames <= frames + 1;
        e = 0;
      end
    end
  end
endmodule : usm_slave
`default_nettype wire

// File: verif/usm_master_test.sv
`default_nettype none
module usm_master_test;
  timeunit 1ns;
  timeprecision 1ns;
  import usm_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst, pol, pha, ord, tx_en, rx_en, div_wr, dw_wr, dw_rd, done_clr, arm;
  logic [1:0] mode;
  logic [11:0] div_wd, rate_div;
  logic [7:0] dw_wd, reply, rdata, got;
  logic done, tbe, rxf, fe, ovr, pe, sck, mosi, oe_n, miso, owned;
  int frames;
  int n_fail = 0;
  int samples_checked = 0;
  logic [7:0] tx_q[$];

  usm_master uut (
    .sys_clk(sys_clk), .nrst(nrst), .mode_select_field(mode),
    .clock_polarity_sel(pol), .clock_phase_sel(pha), .bit_order_sel(ord),
    .tx_enable_bit(tx_en), .rx_enable_bit(rx_en), .rate_divisor_wr(div_wr),
    .rate_divisor_wdata(div_wd), .rate_divisor(rate_div), .data_window_wr(dw_wr),
    .data_window_wdata(dw_wd), .data_window_rd(dw_rd), .data_window_rdata(rdata),
    .tx_done_clr(done_clr), .tx_done_flag(done), .tx_buf_empty_flag(tbe),
    .rx_full_flag(rxf), .framing_err_flag(fe), .overrun_flag(ovr),
    .parity_err_flag(pe), .xfer_clock_pin(sck), .serial_out_pin(mosi),
    .serial_out_oe_n(oe_n), .serial_in_pin(miso), .serial_in_owned(owned)
  );
  usm_slave peer (
    .sck(sck), .mosi(mosi), .miso(miso), .pol(pol), .pha(pha), .lsb_first(ord),
    .arm(arm), .reply(reply), .got(got), .frames(frames)
  );

  // System clock, 100 ns period.
  always #50 sys_clk = ~sys_clk;

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  task automatic stall(input string what);
    n_fail++;
    $display("ERROR %s expected 1 seen 0", what);
    results();
  endtask : stall

  // Each frame seen by the far side must match the oldest byte written.
  always @(frames) begin
    if (frames > 0) begin
      if (tx_q.size() == 0) check("unexpected frame", 16'h0001, 16'h0000);
      else check("captured byte", got, tx_q.pop_front());
    end
  end

  task automatic wr(input logic [7:0] b);
    int c;
    c = 0;
    while (tbe !== 1'b1) begin
      c++;
      if (c > 500) stall("tx_buf_empty_flag");
      @(negedge sys_clk);
    end
    dw_wr = 1'b1;
    dw_wd = b;
    tx_q.push_back(b);
    @(negedge sys_clk);
    dw_wr = 1'b0;
  endtask : wr

  task automatic send(input logic [7:0] b);
    done_clr = 1'b1;
    @(negedge sys_clk);
    done_clr = 1'b0;
    wr(b);
  endtask : send

  task automatic wait_done;
    int c;
    c = 0;
    while (done !== 1'b1) begin
      c++;
      if (c > 2000) stall("tx_done_flag");
      @(negedge sys_clk);
    end
  endtask : wait_done

  task automatic rd(input logic [7:0] exp);
    int c;
    c = 0;
    while (rxf !== 1'b1) begin
      c++;
      if (c > 500) stall("rx_full_flag");
      @(negedge sys_clk);
    end
    check("data_window_rdata", rdata, exp);
    dw_rd = 1'b1;
    @(negedge sys_clk);
    dw_rd = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask : rd

  task automatic setdiv(input logic [11:0] d);
    div_wr = 1'b1;
    div_wd = d;
    @(negedge sys_clk);
    div_wr = 1'b0;
    @(negedge sys_clk);
    check("rate_divisor", rate_div, d);
  endtask : setdiv

  // Mode bits change only while idle, with the far side held in reset.
  task automatic setmode(input logic [2:0] m);
    arm = 1'b0;
    {ord, pha, pol} = m;
    repeat (3) @(negedge sys_clk);
    arm = 1'b1;
  endtask : setmode

  task automatic period(input int exp);
    int c;
    logic l;
    for (int k = 0; k < 2; k++) begin
      l = sck;
      c = 0;
      while (sck === l && c < 200) begin
        @(posedge sys_clk);
        #1;
        c++;
      end
    end
    check("half period", c[15:0], exp[15:0]);
  endtask : period

  // Main sequence.
  initial begin
    int d, f;
    logic [7:0] r[3];
    {nrst, pol, pha, ord, tx_en, rx_en, div_wr, dw_wr, dw_rd, done_clr, arm} = '0;
    {mode, div_wd, dw_wd, reply} = {2'h3, 12'h000, 8'h00, 8'h00};
    d = $urandom(8626);
    repeat (4) @(negedge sys_clk);
    nrst = 1'b1;
    @(negedge sys_clk);
    check("rate_divisor", rate_div, USM_DIV_RST);
    check("tx_buf_empty_flag", tbe, USM_TBE_RST);
    check("error flags", {fe, ovr, pe}, 3'h0);
    tx_en = 1'b1;
    rx_en = 1'b1;
    repeat (2) @(negedge sys_clk);
    check("serial_out_oe_n", oe_n, 1'b0);
    check("serial_in_owned", owned, 1'b1);
    $display("test reset done");
    for (int m = 0; m < 8; m++) begin
      setmode(m[2:0]);
      d = 2 + $urandom % 4;
      setdiv(d[11:0]);
      reply = $urandom;
      send($urandom);
      period(d + 1);
      wait_done();
      // The data line goes idle one cycle after the final clock edge.
      @(negedge sys_clk);
      check("idle clock", sck, pol);
      check("idle data", mosi, USM_LINE_IDLE);
      rd(reply);
    end
    $display("test modes done");
    for (int i = 0; i < 3; i++) begin
      r[i] = $urandom;
      reply = r[i];
      send($urandom);
      wait_done();
    end
    rd(r[0]);
    rd(r[1]);
    check("rx_full_flag", rxf, 1'b0);
    $display("test overflow done");
    setmode(3'h0);
    mode = 2'h2;
    f = frames;
    send(8'ha5);
    repeat (40) @(negedge sys_clk);
    check("frames outside master", frames[15:0], f[15:0]);
    check("tx_done_flag", done, 1'b0);
    mode = 2'h3;
    wait_done();
    rd(reply);
    $display("test mode select done");
    rx_en = 1'b0;
    f = frames + 2;
    send($urandom);
    wr($urandom);
    tx_en = 1'b0;
    wait_done();
    check("frames at done", frames[15:0], f[15:0]);
    check("rx_full_flag", rxf, 1'b0);
    check("serial_in_owned", owned, 1'b0);
    repeat (2) @(negedge sys_clk);
    check("serial_out_oe_n", oe_n, 1'b1);
    $display("test disable done");
    check("frames pending", 16'(tx_q.size()), 16'h0000);
    results();
  end
endmodule : usm_master_test
`default_nettype wire
